// File: mrs_pkg.sv
// Package for the motor run-control arbitration block.
// Assumes a single 25 MHz clock and a plain strobe register port.
// How it works
// RULE1: Sensor interrupt events are ignored for motor control during ramp-up and ramp-down.
// RULE2: Once ramp-up ends and the motor runs at final speed, sensor interrupts are acted upon.
// RULE3: During ramp phases only a host stop request (run bit written 0) changes motor operation.
// RULE4: A stop during ramp-up with hard stop enabled halts stepping at once, even with ramp-down on.
// RULE5: A stop during ramp-up with hard stop off and ramp-down on starts ramping down to a stop.
// RULE6: A stop during ramp-up with hard stop and ramp-down both off halts stepping at once.
// RULE7: A stop during ramp-down with hard stop enabled halts at once, dropping the rest of the ramp.
// RULE8: A stop during ramp-down with hard stop off and ramp-down on keeps decelerating to a stop.
// RULE9: Between ramp-up end and ramp-down start, enabled interrupt controls may change the run.
// RULE10: With reverse-on-interrupt, a sensor event at constant speed reverses and restarts the count.
// RULE11: Without further events the programmed rotations complete and ramp-down follows.
// RULE12: With extra steps enabled for the pin, those steps run first, then direction reverses.
// RULE13: The outside circuit supplies clean, debounced logic levels on the sensor pins.
// RULE14: A pin interrupts only when configured as input, unmasked, and its selected edge occurs.
// RULE15: A stop at constant speed follows the same hard-stop then ramp-down priority as ramp-up.
package mrs_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] OFS_RUN = 4'h0;
    localparam logic [3:0] OFS_CFG = 4'h1;
    localparam logic [3:0] OFS_ROT = 4'h2;
    localparam logic [3:0] OFS_STEPS = 4'h3;
    localparam logic [3:0] OFS_RAMP = 4'h4;
    localparam logic [3:0] OFS_EXTRA = 4'h5;
    localparam logic [3:0] OFS_IOC = 4'h6;
    localparam logic [3:0] OFS_EDGE = 4'h7;
    localparam logic [3:0] OFS_PINMSK = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'h9;
    localparam logic [3:0] OFS_IMSK = 4'hA;
    localparam logic [3:0] OFS_PHASE = 4'hB;
    localparam logic [3:0] OFS_RATE = 4'hC;
    // Run control fields
    localparam int RUN_BIT = 7;
    localparam int DIR_BIT = 0;
    // Config fields
    localparam int CFG_HARD = 0;
    localparam int CFG_RDOWN = 1;
    localparam int CFG_RUP = 2;
    localparam int CFG_REV = 3;
    localparam int CFG_STOPINT = 4;
    // Status fields
    localparam int ST_PIN0 = 0;
    localparam int ST_DONE = 4;
    // Reset values
    localparam logic [7:0] RST_ROT = 8'h01;
    localparam logic [7:0] RST_STEPS = 8'h30;
    localparam logic [7:0] RST_RAMP = 8'h08;
    localparam logic [7:0] RST_RATE = 8'h10;
    localparam logic [7:0] RST_IOC = 8'h0F;
    localparam logic [7:0] RST_PINMSK = 8'h0F;
    // Timing: unit step period base
    localparam int STEP_BASE_NS = 40960;
    localparam int CLK_NS = 40;
    localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_NS;
    typedef enum logic [2:0] {MRS_IDLE, MRS_RAMP_UP, MRS_CONST, MRS_EXTRA, MRS_RAMP_DOWN} mrs_state_t;
endpackage : mrs_pkg

// File: mrs_edge.sv
// Sensor pin synchroniser and edge qualifier, one lane per pin.
// Assumes pins are clean logic levels from outside the clock domain.
`timescale 1ns/10ps
module mrs_edge #(
    parameter int PINS = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [PINS-1:0] pin,
    input wire logic [PINS-1:0] is_input,
    input wire logic [PINS-1:0] enable,
    input wire logic [PINS-1:0] rising,
    output logic [PINS-1:0] event_pulse,
    output logic [PINS-1:0] level
);
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_lane
            logic s1;
            logic s2;
            logic s3;
            // Two-stage sync plus history; no debounce
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= pin[g];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            // Input, unmasked, selected edge
            assign event_pulse[g] = is_input[g] && enable[g] &&
                (rising[g] ? (s2 && !s3) : (!s2 && s3)); // RULE14 RULE13
            assign level[g] = s3;
        end
    endgenerate
endmodule : mrs_edge

// File: mrs_top.sv
// Run-control arbitration for a four-phase stepper sequencer.
// Assumes a host on the strobe register port and clean sensor levels.
`timescale 1ns/10ps
module mrs_top #(
    parameter int PINS = 4,
    parameter int STEP_BASE = mrs_pkg::STEP_BASE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [mrs_pkg::ADDR_W-1:0] addr,
    input wire logic [mrs_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [mrs_pkg::DATA_W-1:0] rdata,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_b,
    output logic [3:0] coil,
    output logic irq
);
    import mrs_pkg::*;

    // Host registers
    logic [7:0] run_ctl;
    logic [7:0] cfg;
    logic [7:0] rot;
    logic [7:0] steps;
    logic [7:0] ramp_len;
    logic [7:0] extra;
    logic [7:0] ioc;
    logic [7:0] edge_sel;
    logic [7:0] pin_msk;
    logic [7:0] stat;
    logic [7:0] imsk;
    logic [7:0] rate;
    logic [7:0] pout;
    // Sequencer state and counters
    mrs_state_t state;
    logic dir;
    logic [7:0] rot_left;
    logic [7:0] step_left;
    logic [7:0] ramp_pos;
    logic [7:0] extra_left;
    logic [2:0] phase;
    logic [23:0] tick_cnt;
    // Internal strobes and events
    logic [PINS-1:0] pin_ev;
    logic step_tick;
    logic stop_req;
    logic start_req;
    logic any_ev;
    logic ev_extra;
    logic [7:0] next_stat;
    logic [23:0] period;
    logic done_ev;

    mrs_edge #(.PINS(PINS)) i_mrs_edge (
        .clock(clock),
        .rst_b(rst_b),
        .pin(pin_in),
        .is_input(ioc[PINS-1:0]),
        .enable(pin_msk[PINS-1:0]),
        .rising(edge_sel[PINS-1:0]),
        .event_pulse(pin_ev),
        .level()
    );

    // Host run-bit writes
    assign stop_req = wr && (addr == OFS_RUN) && !wdata[RUN_BIT] && (state != MRS_IDLE); // RULE3
    assign start_req = wr && (addr == OFS_RUN) && wdata[RUN_BIT] && (state == MRS_IDLE);
    assign any_ev = |pin_ev;
    assign ev_extra = |(pin_ev & extra[PINS-1:0]);

    // Step period: base rate at full speed, longer on a ramp; 24 bits hold the default base
    always_comb begin
        period = 24'(STEP_BASE) * {16'h0000, rate};
        case (state)
            // Ramp-up shortens the period as the position climbs
            MRS_RAMP_UP: period = period + 24'(STEP_BASE) * {16'h0000, ramp_len - ramp_pos};
            // Ramp-down lengthens it; a cut ramp-up enters at the mirrored position
            MRS_RAMP_DOWN: period = period + 24'(STEP_BASE) * {16'h0000, ramp_pos};
            default: ;
        endcase
    end

    // Step rate timer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 24'h000000;
        end else if (state == MRS_IDLE || tick_cnt + 24'h000001 >= period) begin
            tick_cnt <= 24'h000000;
        end else begin
            tick_cnt <= tick_cnt + 24'h000001;
        end
    end
    assign step_tick = (state != MRS_IDLE) && (tick_cnt + 24'h000001 >= period);

    // Run sequencer with stop and interrupt arbitration
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= MRS_IDLE;
            dir <= 1'b0;
            rot_left <= 8'h00;
            step_left <= 8'h00;
            ramp_pos <= 8'h00;
            extra_left <= 8'h00;
        end else begin
            case (state)
                // Idle: a run write loads the counts
                MRS_IDLE: begin
                    if (start_req) begin
                        dir <= wdata[DIR_BIT];
                        rot_left <= rot;
                        step_left <= steps;
                        ramp_pos <= 8'h00;
                        state <= cfg[CFG_RUP] ? MRS_RAMP_UP : MRS_CONST;
                    end
                end
                MRS_RAMP_UP: begin
                    // Sensor events ignored here
                    if (stop_req) begin // RULE1
                        if (cfg[CFG_HARD]) begin
                            state <= MRS_IDLE; // RULE4
                        end else if (cfg[CFG_RDOWN]) begin
                            ramp_pos <= ramp_len - ramp_pos;
                            state <= MRS_RAMP_DOWN; // RULE5
                        end else begin
                            state <= MRS_IDLE; // RULE6
                        end
                    end else if (step_tick) begin
                        if (ramp_pos + 8'h01 >= ramp_len) begin
                            ramp_pos <= 8'h00;
                            state <= MRS_CONST; // RULE2
                        end else begin
                            ramp_pos <= ramp_pos + 8'h01;
                        end
                    end
                end
                // Constant speed: host stop first, then sensor controls
                MRS_CONST: begin
                    if (stop_req) begin
                        if (cfg[CFG_HARD] || !cfg[CFG_RDOWN]) begin
                            state <= MRS_IDLE; // RULE15
                        end else begin
                            ramp_pos <= 8'h00;
                            state <= MRS_RAMP_DOWN; // RULE15
                        end
                    end else if (any_ev && cfg[CFG_STOPINT]) begin
                        state <= MRS_IDLE; // RULE9
                    end else if (any_ev && cfg[CFG_REV] && ev_extra && extra_left == 8'h00) begin
                        extra_left <= extra;
                        state <= MRS_EXTRA; // RULE12
                    end else if (any_ev && cfg[CFG_REV]) begin
                        dir <= ~dir;
                        rot_left <= rot;
                        step_left <= steps; // RULE10 RULE2
                    end else if (step_tick) begin
                        if (step_left > 8'h01) begin
                            step_left <= step_left - 8'h01;
                        end else if (rot_left > 8'h01) begin
                            rot_left <= rot_left - 8'h01;
                            step_left <= steps;
                        end else begin
                            ramp_pos <= 8'h00;
                            state <= cfg[CFG_RDOWN] ? MRS_RAMP_DOWN : MRS_IDLE; // RULE11
                        end
                    end
                end
                // Extra steps in the present direction, then reverse
                MRS_EXTRA: begin
                    if (stop_req) begin
                        if (cfg[CFG_HARD] || !cfg[CFG_RDOWN]) begin
                            state <= MRS_IDLE;
                        end else begin
                            ramp_pos <= 8'h00;
                            state <= MRS_RAMP_DOWN;
                        end
                    end else if (extra_left == 8'h00) begin
                        dir <= ~dir;
                        rot_left <= rot;
                        step_left <= steps;
                        state <= MRS_CONST; // RULE12
                    end else if (step_tick) begin
                        extra_left <= extra_left - 8'h01;
                    end
                end
                // Ramp-down: only a hard stop cuts it short
                MRS_RAMP_DOWN: begin
                    if (stop_req && cfg[CFG_HARD]) begin // RULE1
                        state <= MRS_IDLE; // RULE7
                    end else if (step_tick) begin
                        if (ramp_pos + 8'h01 >= ramp_len) begin
                            state <= MRS_IDLE; // RULE8
                        end else begin
                            ramp_pos <= ramp_pos + 8'h01;
                        end
                    end
                end
                default: begin
                    state <= MRS_IDLE;
                end
            endcase
        end
    end

    // Phase pointer steps with direction
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 3'h0;
        end else if (step_tick) begin
            phase <= dir ? phase - 3'h1 : phase + 3'h1;
        end
    end

    // Half-step coil pattern, coils off when idle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coil <= 4'h0;
        end else if (state == MRS_IDLE) begin
            coil <= 4'h0;
        end else begin
            case (phase)
                3'h0: coil <= 4'h8;
                3'h1: coil <= 4'hC;
                3'h2: coil <= 4'h4;
                3'h3: coil <= 4'h6;
                3'h4: coil <= 4'h2;
                3'h5: coil <= 4'h3;
                3'h6: coil <= 4'h1;
                default: coil <= 4'h9;
            endcase
        end
    end

    // Motor finished event
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_ev <= 1'b0;
        end else begin
            done_ev <= (state != MRS_IDLE);
        end
    end

    // Sticky status, set wins over read clear
    always_comb begin
        next_stat = stat;
        if (rd && addr == OFS_STAT) begin
            next_stat = 8'h00;
        end
        next_stat[PINS-1:0] = next_stat[PINS-1:0] | pin_ev;
        if (done_ev && state == MRS_IDLE) begin
            next_stat[ST_DONE] = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stat <= 8'h00;
        end else begin
            stat <= next_stat;
        end
    end
    assign irq = |(stat & imsk);

    // Register writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_ctl <= 8'h00;
            cfg <= 8'h00;
            rot <= RST_ROT;
            steps <= RST_STEPS;
            ramp_len <= RST_RAMP;
            extra <= 8'h00;
            ioc <= RST_IOC;
            edge_sel <= 8'h00;
            pin_msk <= RST_PINMSK;
            imsk <= 8'h00;
            rate <= RST_RATE;
            pout <= 8'h00;
        end else if (wr) begin
            case (addr)
                OFS_RUN: run_ctl <= wdata;
                OFS_CFG: cfg <= wdata;
                OFS_ROT: rot <= wdata;
                OFS_STEPS: steps <= wdata;
                OFS_RAMP: ramp_len <= wdata;
                OFS_EXTRA: extra <= wdata;
                OFS_IOC: ioc <= wdata;
                OFS_EDGE: edge_sel <= wdata;
                OFS_PINMSK: pin_msk <= wdata;
                OFS_IMSK: imsk <= wdata;
                OFS_RATE: rate <= (wdata == 8'h00) ? 8'h01 : wdata;
                OFS_PHASE: pout <= wdata;
                default: ;
            endcase
        end
    end

    // GPIO outputs drive when configured as outputs
    assign pin_out = pout[PINS-1:0];
    assign pin_oe_b = ioc[PINS-1:0];

    // Read data one cycle after strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                OFS_RUN: rdata <= {(state != MRS_IDLE), run_ctl[6:1], dir};
                OFS_CFG: rdata <= cfg;
                OFS_ROT: rdata <= rot;
                OFS_STEPS: rdata <= steps;
                OFS_RAMP: rdata <= ramp_len;
                OFS_EXTRA: rdata <= extra;
                OFS_IOC: rdata <= ioc;
                OFS_EDGE: rdata <= edge_sel;
                OFS_PINMSK: rdata <= pin_msk;
                OFS_STAT: rdata <= stat;
                OFS_IMSK: rdata <= imsk;
                OFS_PHASE: rdata <= {1'b0, state, 1'b0, phase};
                OFS_RATE: rdata <= rate;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : mrs_top

// File: mrs_top_assertions.sv
// Port checker for the run-control block.
// Assumes only the ports of mrs_top; bound below.
`timescale 1ns/10ps
module mrs_chk #(
    parameter int PINS = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [mrs_pkg::ADDR_W-1:0] addr,
    input wire logic [mrs_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [mrs_pkg::DATA_W-1:0] rdata,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_b,
    input wire logic [3:0] coil,
    input wire logic irq
);
    import mrs_pkg::*;
    logic [7:0] cfg;
    logic [7:0] imsk;
    logic imsk_set;
    logic [7:0] ioc;
    logic [2:0] quiet;
    logic [PINS-1:0] pin_d;
    // Shadows of written registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= 8'h00;
            imsk <= 8'h00;
            imsk_set <= 1'b0;
            ioc <= RST_IOC;
        end else if (wr) begin
            if (addr == OFS_CFG) cfg <= wdata;
            if (addr == OFS_IMSK) imsk <= wdata;
            if (addr == OFS_IMSK) imsk_set <= 1'b1;
            if (addr == OFS_IOC) ioc <= wdata;
        end
    end
    // Cycles the pins have stayed still
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            quiet <= 3'h0;
            pin_d <= '0;
        end else begin
            pin_d <= pin_in;
            quiet <= (pin_in != pin_d) ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_RD_QUIET: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property (rd && addr == 4'hF |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_OE_IOC: assert property (wr && addr == OFS_IOC |=> pin_oe_b == ioc[PINS-1:0])
        else $error("pin enable differs from direction");
    AST_HARD_STOP: assert property (wr && addr == OFS_RUN && !wdata[RUN_BIT] && cfg[CFG_HARD] |-> ##[1:4] coil == 4'h0)
        else $error("hard stop did not halt");
    AST_PLAIN_STOP: assert property (wr && addr == OFS_RUN && !wdata[RUN_BIT] && cfg[2:0] == 3'h4 |-> ##[1:4] coil == 4'h0)
        else $error("stop without ramp did not halt");
    AST_IRQ_MASKED: assert property (irq |-> imsk_set && imsk[4:0] != 5'h00)
        else $error("masked interrupt raised");
    AST_IRQ_STICKY: assert property (irq && !(rd && addr == OFS_STAT) && !(wr && addr == OFS_IMSK) |=> irq)
        else $error("interrupt dropped without read");
    AST_IRQ_CLEAR: assert property (rd && addr == OFS_STAT && quiet == 3'h7 && imsk_set && !imsk[ST_DONE] |=> !irq)
        else $error("status read left interrupt");
endmodule : mrs_chk
bind mrs_top mrs_chk #(.PINS(PINS)) i_mrs_chk (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .coil(coil), .irq(irq));

// File: mrs_sensor.sv
// Sensor model on the GPIO pins.
// Assumes the bench asks for levels; driven pins echo the block.
`timescale 1ns/10ps
module mrs_sensor (
    input wire logic clock,
    input wire logic [3:0] want,
    input wire logic [3:0] oe_b,
    input wire logic [3:0] drv,
    output logic [3:0] pin
);
    logic [3:0] held = 4'h0;
    // Clean levels, moved only at an edge
    always @(posedge clock) held <= want;
    // Wire level from both parties
    assign pin = (oe_b & held) | (~oe_b & drv);
endmodule : mrs_sensor

// File: test_motor_ramp_stop_priority.sv
// Self-checking bench for the run-control block.
// Assumes one 25 MHz clock and the sensor model on the pins.
`timescale 1ns/10ps
module test_motor_ramp_stop_priority;
    import mrs_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] want = 4'h0;
    logic [7:0] rdata;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_b;
    logic [3:0] coil;
    logic irq;
    logic [7:0] expq[$];
    logic [7:0] cfgs[3] = '{8'h17, 8'h14, 8'h16};
    logic [7:0] rnd;
    int fails = 0;
    int checked = 0;
    int seed = 40444;
    mrs_top #(.PINS(4), .STEP_BASE(4)) i_mrs_top (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .coil(coil), .irq(irq));
    mrs_sensor i_mrs_sensor (.clock(clock), .want(want), .oe_b(pin_oe_b), .drv(pin_out), .pin(pin_in));
    // Clock
    initial forever #20 clock = ~clock;
    task automatic complete_run;
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : put
    task automatic get(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask : get
    task automatic pin(input int n, input logic v);
        want[n] <= v;
        repeat (8) @(posedge clock);
    endtask : pin
    task automatic running(input logic exp);
        repeat (4) @(posedge clock);
        @(negedge clock);
        cmp({7'h0, coil != 4'h0}, {7'h0, exp}, "run");
    endtask : running
    task automatic halt;
        for (int n = 0; n < 20000 && coil !== 4'h0; n++) @(posedge clock);
        cmp({4'h0, coil}, 8'h00, "coil");
    endtask : halt
    // Read answers against the oldest note
    always @(posedge clock) begin
        if (rd_d) cmp(rdata, expq.pop_front(), "read");
        rd_d <= rd;
    end
    // Watchdog
    initial begin
        repeat (95000) @(posedge clock);
        fails++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        get(OFS_ROT, RST_ROT);
        get(OFS_STEPS, RST_STEPS);
        get(OFS_RAMP, RST_RAMP);
        get(OFS_RATE, RST_RATE);
        get(OFS_IOC, RST_IOC);
        get(OFS_PINMSK, RST_PINMSK);
        get(4'hF, 8'h00);
        get(OFS_STAT, 8'h00);
        // Edge, mask and direction qualify events
        put(OFS_EDGE, 8'h0B);
        put(OFS_PINMSK, 8'h0D);
        put(OFS_IMSK, 8'h01);
        pin(1, 1'b1);
        get(OFS_STAT, 8'h00);
        pin(2, 1'b1);
        get(OFS_STAT, 8'h00);
        pin(2, 1'b0);
        get(OFS_STAT, 8'h04);
        pin(0, 1'b1);
        cmp({7'h0, irq}, 8'h01, "irq");
        get(OFS_STAT, 8'h01);
        cmp({7'h0, irq}, 8'h00, "irq");
        pin(0, 1'b0);
        put(OFS_IOC, 8'h0E);
        rnd = 8'($random(seed));
        put(OFS_PHASE, rnd & 8'hFE);
        @(negedge clock);
        cmp({4'h0, pin_oe_b}, 8'h0E, "oe");
        cmp({4'h0, pin_out}, {4'h0, rnd[3:1], 1'b0}, "gpo");
        pin(0, 1'b1);
        pin(0, 1'b0);
        get(OFS_STAT, 8'h00);
        put(OFS_IOC, 8'h0F);
        // Stop during ramp-up, three settings
        put(OFS_RAMP, 8'h20);
        put(OFS_ROT, 8'hFF);
        put(OFS_STEPS, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            put(OFS_CFG, cfgs[k]);
            put(OFS_RUN, 8'h80);
            pin(0, 1'b1);
            running(1'b1);
            put(OFS_RUN, 8'h00);
            running(k == 2);
            halt();
            get(OFS_STAT, 8'h11);
            pin(0, 1'b0);
        end
        // Events act at constant speed
        put(OFS_RAMP, 8'h04);
        put(OFS_CFG, 8'h11);
        put(OFS_RUN, 8'h80);
        repeat (4000) @(posedge clock);
        pin(0, 1'b1);
        running(1'b0);
        get(OFS_STAT, 8'h11);
        pin(0, 1'b0);
        put(OFS_CFG, 8'h08);
        put(OFS_RUN, 8'h80);
        repeat (4000) @(posedge clock);
        get(OFS_RUN, 8'h80);
        pin(0, 1'b1);
        running(1'b1);
        get(OFS_RUN, 8'h81);
        pin(0, 1'b0);
        pin(0, 1'b1);
        get(OFS_RUN, 8'h80);
        // Extra steps run in the old direction first
        put(OFS_EXTRA, 8'h0F);
        pin(0, 1'b0);
        pin(0, 1'b1);
        get(OFS_RUN, 8'h80);
        repeat (1100) @(posedge clock);
        get(OFS_RUN, 8'h81);
        put(OFS_CFG, 8'h09);
        put(OFS_RUN, 8'h00);
        running(1'b0);
        pin(0, 1'b0);
        // Stop at speed, then stops during ramp-down
        put(OFS_CFG, 8'h02);
        put(OFS_RUN, 8'h80);
        repeat (4000) @(posedge clock);
        put(OFS_RUN, 8'h00);
        running(1'b1);
        put(OFS_RUN, 8'h00);
        running(1'b1);
        put(OFS_CFG, 8'h03);
        put(OFS_RUN, 8'h00);
        running(1'b0);
        get(OFS_STAT, 8'h11);
        // Count runs out, ramp-down only when enabled
        put(OFS_ROT, 8'h01);
        put(OFS_STEPS, 8'h02);
        for (int j = 0; j < 2; j++) begin
            put(OFS_CFG, {6'h00, j[0], 1'b0});
            put(OFS_RUN, 8'h80);
            repeat (200) @(posedge clock);
            running(j == 1);
            halt();
            get(OFS_STAT, 8'h10);
        end
        complete_run();
    end
endmodule : test_motor_ramp_stop_priority
